/* src/bit_manipulation_exec_unit.sv */
`timescale 1ns/1ps
// Functional notes
// - 8B: C and bit, or not bit, 4 cycles
// - test: Z from A and M, N=M7, V=M6
// - direct-page bit clear, flags kept, 4 cycles
// - 2B clears accumulator bit in 2 cycles
// - 20 clears C, A0 sets C, 2 cycles
// - 40 clears G, C0 sets G, 2 cycles
// - 80 clears V in 2 cycles
// - AB: C xor bit or not bit, 5 cycles
// - load carry from bit or not bit, 4 cycles
// - 4B inverts memory bit, 5 cycles
// - 6B: C or bit or not bit, 5 cycles
// - direct-page bit set, flags kept, 4 cycles
// - 0B sets accumulator bit in 2 cycles
// - EB stores C into memory bit, 6 cycles
// - 5C: N,Z from A-M, write M and not A
// - 3C: N,Z from A-M, write M or A
module bit_manipulation_exec_unit (
   input  wire logic        clk_sys_i,
   input  wire logic        nrst_i,
   input  wire logic        start_i,
   input  wire logic [7:0]  opcode_i,
   input  wire logic [7:0]  byte1_i,
   input  wire logic [7:0]  byte2_i,
   input  wire logic [7:0]  acc_i,
   input  wire logic [7:0]  psw_i,
   input  wire logic [7:0]  mem_rdata_i,
   output logic             busy_o,
   output logic             done_o,
   output logic             illegal_o,
   output logic [7:0]       acc_o,
   output logic [7:0]       psw_o,
   output logic             mem_rd_o,
   output logic             mem_wr_o,
   output logic [15:0]      mem_addr_o,
   output logic [7:0]       mem_wdata_o
);
   import bit_manip_pkg::*;

   // ****************************************************************
   // reset release
   // ****************************************************************
   logic rst_meta_ff;
   logic rst_sync_ff;

   // asynchronous assert, release through two flops
   // all flops leave reset on one edge
   // assert stays async for a dead clock
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   // ****************************************************************
   // decode
   // ****************************************************************
   op_class_type dec_cls;
   logic [2:0]   dec_cyc;
   logic [15:0]  dec_addr;
   logic [2:0]   dec_bitn;
   logic         dec_inv;
   logic         dec_rd;
   logic         dec_wr;

   // page flag taken from the status word presented with the opcode
   // inputs are used only at the start edge
   // so the core may move on while busy
   bit_op_decode u_decode (
      .opcode_i (opcode_i),
      .byte1_i  (byte1_i),
      .byte2_i  (byte2_i),
      .page_i   (psw_i[PSW_G]),
      .cls_o    (dec_cls),
      .cyc_o    (dec_cyc),
      .addr_o   (dec_addr),
      .bitn_o   (dec_bitn),
      .inv_o    (dec_inv),
      .rd_o     (dec_rd),
      .wr_o     (dec_wr)
   );

   // one-hot mask of a bit number; used for memory and accumulator paths
   // one function, one bit order for both
   function automatic logic [7:0] bit_mask(input logic [2:0] n);
      bit_mask = BYTE_ONE << n;
   endfunction

   // ****************************************************************
   // sequencing
   // ****************************************************************
   // cycle plan, n-cycle form:
   //   c0   start seen, context copied
   //   c1   busy, read strobe, address
   //   c2   read byte in, results built
   //   c3.. spacing to the form's length
   //   cn-1 done, write strobe if any
   //   cn   free, next start taken
   // short forms end in c1, no strobes
   logic         busy_ff;
   logic         done_ff;
   logic         illegal_ff;
   logic [2:0]   cnt_ff;
   logic [2:0]   tot_ff;
   op_class_type cls_ff;
   logic [2:0]   bitn_ff;
   logic         inv_ff;
   logic         wr_need_ff;
   logic         accept;
   logic         capture;
   logic         last_cycle;
   logic         before_last;

   // a start while busy is dropped; the core waits for done
   // dropping, not queueing: no buffer
   assign accept      = start_i && !busy_ff && (dec_cls != CL_NONE);
   assign capture     = busy_ff && (cnt_ff == CNT_CAP);
   assign before_last = busy_ff && (cnt_ff == (tot_ff - CNT_DONE_ADV));
   assign last_cycle  = busy_ff && (cnt_ff == (tot_ff - CNT_FIRST));

   // cycle counter: the start cycle is cycle 0
   // three bits cover six cycles
   always_ff @(posedge clk_sys_i or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         cnt_ff <= 3'h0;
      end else if (accept) begin
         cnt_ff <= CNT_FIRST;
      end else if (busy_ff) begin
         cnt_ff <= cnt_ff + CNT_FIRST;
      end
   end

   // busy from cycle 1 through the last cycle of the instruction
   // busy falls at the end of cycle n-1
   always_ff @(posedge clk_sys_i or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         busy_ff <= 1'b0;
      end else if (accept) begin
         busy_ff <= 1'b1;
      end else if (last_cycle) begin
         busy_ff <= 1'b0;
      end
   end

   // done marks the last cycle; short ops end in cycle 1
   // short forms have no c2, set at start
   always_ff @(posedge clk_sys_i or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         done_ff <= 1'b0;
      end else if (accept) begin
         done_ff <= (dec_cyc == CYC_SHORT);
      end else begin
         done_ff <= before_last;
      end
   end

   // unknown opcode reported for one cycle, nothing else happens
   // no state moves for an illegal start
   always_ff @(posedge clk_sys_i or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         illegal_ff <= 1'b0;
      end else begin
         illegal_ff <= start_i && !busy_ff && (dec_cls == CL_NONE);
      end
   end

   // instruction context held for the whole execution
   // tot_ff resets short, compares defined
   always_ff @(posedge clk_sys_i or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         tot_ff     <= CYC_SHORT;
         cls_ff     <= CL_NONE;
         bitn_ff    <= 3'h0;
         inv_ff     <= 1'b0;
         wr_need_ff <= 1'b0;
      end else if (accept) begin
         tot_ff     <= dec_cyc;
         cls_ff     <= dec_cls;
         bitn_ff    <= dec_bitn;
         inv_ff     <= dec_inv;
         wr_need_ff <= dec_wr;
      end
   end

   // ****************************************************************
   // data path
   // ****************************************************************
   logic [7:0]  acc_ff;
   logic [7:0]  psw_ff;
   logic [7:0]  mask;
   logic        mbit;
   logic [7:0]  diff;
   logic [7:0]  nxt_wdata;
   logic [7:0]  nxt_psw;

   // mbit carries the optional inversion,
   // so both forms share one equation
   // diff feeds N and Z of test-and-modify
   assign mask = bit_mask(bitn_ff);
   assign mbit = ((mem_rdata_i & mask) != BYTE_ZERO) ^ inv_ff;
   assign diff = acc_ff - mem_rdata_i;

   // memory byte to write back, built from the byte on the bus
   // valid in the capture cycle only
   always_comb begin
      nxt_wdata = mem_rdata_i;
      unique case (cls_ff)
         CL_MINV:   nxt_wdata = mem_rdata_i ^ mask;
         CL_MSET:   nxt_wdata = mem_rdata_i | mask;
         CL_MCLR:   nxt_wdata = mem_rdata_i & ~mask;
         CL_CSTORE: nxt_wdata = psw_ff[PSW_C] ? (mem_rdata_i | mask)
                                              : (mem_rdata_i & ~mask);
         CL_TCLR:   nxt_wdata = mem_rdata_i & ~acc_ff;
         CL_TSET:   nxt_wdata = mem_rdata_i | acc_ff;
         default:   nxt_wdata = mem_rdata_i;
      endcase
   end

   // flags from the byte on the bus; only the named bits move
   // unnamed bits pass through from psw_ff
   always_comb begin
      nxt_psw = psw_ff;
      unique case (cls_ff)
         CL_CAND:  nxt_psw[PSW_C] = psw_ff[PSW_C] & mbit;
         CL_COR:   nxt_psw[PSW_C] = psw_ff[PSW_C] | mbit;
         CL_CXOR:  nxt_psw[PSW_C] = psw_ff[PSW_C] ^ mbit;
         CL_CLOAD: nxt_psw[PSW_C] = mbit;
         CL_TEST: begin
            nxt_psw[PSW_Z] = ((acc_ff & mem_rdata_i) == BYTE_ZERO);
            nxt_psw[PSW_N] = mem_rdata_i[PSW_N];
            nxt_psw[PSW_V] = mem_rdata_i[PSW_V];
         end
         CL_TCLR, CL_TSET: begin
            nxt_psw[PSW_N] = diff[PSW_N];
            nxt_psw[PSW_Z] = (diff == BYTE_ZERO);
         end
         default: nxt_psw = psw_ff;
      endcase
   end

   // status word: loaded at start, short ops applied there,
   // memory forms applied when the read byte arrives
   always_ff @(posedge clk_sys_i or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         psw_ff <= PSW_RESET;
      end else if (accept) begin
         psw_ff <= psw_i;
         unique case (dec_cls)
            CL_CCLR: psw_ff[PSW_C] <= 1'b0;
            CL_CSET: psw_ff[PSW_C] <= 1'b1;
            CL_GCLR: psw_ff[PSW_G] <= 1'b0;
            CL_GSET: psw_ff[PSW_G] <= 1'b1;
            CL_VCLR: psw_ff[PSW_V] <= 1'b0;
            default: psw_ff[PSW_C] <= psw_i[PSW_C];
         endcase
      end else if (capture) begin
         psw_ff <= nxt_psw;
      end
   end

   // accumulator: copied at start, bit forms applied there
   // memory forms return acc_i as is
   always_ff @(posedge clk_sys_i or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         acc_ff <= BYTE_ZERO;
      end else if (accept) begin
         unique case (dec_cls)
            CL_ASET: acc_ff <= acc_i | bit_mask(dec_bitn);
            CL_ACLR: acc_ff <= acc_i & ~bit_mask(dec_bitn);
            default: acc_ff <= acc_i;
         endcase
      end
   end

   // ****************************************************************
   // memory bus
   // ****************************************************************
   // no wait states: a read is answered
   // in the cycle after the strobe, else
   // flags and write byte see stale data
   // the write reuses the read address
   logic        mem_rd_ff;
   logic        mem_wr_ff;
   logic [15:0] mem_addr_ff;
   logic [7:0]  mem_wdata_ff;

   // address held from cycle 1 to the end of the instruction
   // kept after done until the next start
   always_ff @(posedge clk_sys_i or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         mem_addr_ff <= ADDR_ZERO;
      end else if (accept) begin
         mem_addr_ff <= dec_addr;
      end
   end

   // read strobe in cycle 1; byte is expected on the bus in cycle 2
   // short forms never read
   always_ff @(posedge clk_sys_i or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         mem_rd_ff <= 1'b0;
      end else begin
         mem_rd_ff <= accept && dec_rd;
      end
   end

   // write data captured with the read byte, held until the write
   always_ff @(posedge clk_sys_i or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         mem_wdata_ff <= BYTE_ZERO;
      end else if (capture) begin
         mem_wdata_ff <= nxt_wdata;
      end
   end

   // write strobe in the last cycle, so a long op keeps its length
   // wdata has stood since c3
   always_ff @(posedge clk_sys_i or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         mem_wr_ff <= 1'b0;
      end else begin
         mem_wr_ff <= before_last && wr_need_ff;
      end
   end

   // outputs straight from flops
   // no output is a same-cycle path
   assign busy_o      = busy_ff;
   assign done_o      = done_ff;
   assign illegal_o   = illegal_ff;
   assign acc_o       = acc_ff;
   assign psw_o       = psw_ff;
   assign mem_rd_o    = mem_rd_ff;
   assign mem_wr_o    = mem_wr_ff;
   assign mem_addr_o  = mem_addr_ff;
   assign mem_wdata_o = mem_wdata_ff;

endmodule // bit_manipulation_exec_unit

/* src/bit_manip_pkg.sv */
`timescale 1ns/1ps
// ****************************************************************
// shared constants and types
// ****************************************************************
package bit_manip_pkg;
   // opcodes of the group
   localparam logic [7:0] OP_CAND   = 8'h8B;
   localparam logic [7:0] OP_CXOR   = 8'hAB;
   localparam logic [7:0] OP_CLOAD  = 8'hCB;
   localparam logic [7:0] OP_COR    = 8'h6B;
   localparam logic [7:0] OP_MINV   = 8'h4B;
   localparam logic [7:0] OP_CSTORE = 8'hEB;
   localparam logic [7:0] OP_TST_DP = 8'h0C;
   localparam logic [7:0] OP_TST_AB = 8'h1C;
   localparam logic [7:0] OP_TCLR   = 8'h5C;
   localparam logic [7:0] OP_TSET   = 8'h3C;
   localparam logic [7:0] OP_ACLR   = 8'h2B;
   localparam logic [7:0] OP_ASET   = 8'h0B;
   localparam logic [7:0] OP_CCLR   = 8'h20;
   localparam logic [7:0] OP_CSET   = 8'hA0;
   localparam logic [7:0] OP_GCLR   = 8'h40;
   localparam logic [7:0] OP_GSET   = 8'hC0;
   localparam logic [7:0] OP_VCLR   = 8'h80;
   localparam logic [3:0] OP_DPBIT_LO = 4'h1;   // low nibble of x1 / y1 families
   // execution lengths in core cycles
   localparam logic [2:0] CYC_CAND   = 3'h4;
   localparam logic [2:0] CYC_CXOR   = 3'h5;
   localparam logic [2:0] CYC_CLOAD  = 3'h4;
   localparam logic [2:0] CYC_COR    = 3'h5;
   localparam logic [2:0] CYC_MINV   = 3'h5;
   localparam logic [2:0] CYC_CSTORE = 3'h6;
   localparam logic [2:0] CYC_TST_DP = 3'h4;
   localparam logic [2:0] CYC_TST_AB = 3'h5;
   localparam logic [2:0] CYC_TSTMOD = 3'h6;
   localparam logic [2:0] CYC_DPBIT  = 3'h4;
   localparam logic [2:0] CYC_SHORT  = 3'h2;
   // counter start and step; CNT_CAP: cycle in which a requested read byte is on the data bus
   localparam logic [2:0] CNT_FIRST  = 3'h1;
   localparam logic [2:0] CNT_CAP    = 3'h2;
   localparam logic [2:0] CNT_DONE_ADV = 3'h2;  // done is set this many before the end
   // status word bit positions (N V G B H I Z C)
   localparam int PSW_N = 7;
   localparam int PSW_V = 6;
   localparam int PSW_G = 5;
   localparam int PSW_Z = 1;
   localparam int PSW_C = 0;
   // memory-bit operand word {byte2, byte1}
   localparam int MB_ADDR_MSB = 11;
   localparam int MB_BIT_LSB  = 12;
   localparam int MB_BIT_MSB  = 14;
   localparam int MB_INV_POS  = 15;
   // opcode fields of the direct-page bit families
   localparam int DP_BIT_LSB  = 5;
   localparam int DP_BIT_MSB  = 7;
   localparam int DP_CLR_POS  = 4;
   localparam int ACC_BIT_MSB = 2;
   localparam logic [3:0] MB_ADDR_PAD = 4'h0;
   localparam logic [6:0] DP_PAGE_PAD = 7'h00;
   localparam logic [7:0] BYTE_ZERO   = 8'h00;
   localparam logic [7:0] BYTE_ONE    = 8'h01;
   localparam logic [15:0] ADDR_ZERO  = 16'h0000;
   localparam logic [7:0] PSW_RESET   = 8'h00;

   typedef enum logic [4:0] {
      CL_NONE   = 5'b00000,
      CL_CAND   = 5'b00001,
      CL_COR    = 5'b00010,
      CL_CXOR   = 5'b00011,
      CL_CLOAD  = 5'b00100,
      CL_MINV   = 5'b00101,
      CL_CSTORE = 5'b00110,
      CL_MSET   = 5'b00111,
      CL_MCLR   = 5'b01000,
      CL_TEST   = 5'b01001,
      CL_TSET   = 5'b01010,
      CL_TCLR   = 5'b01011,
      CL_ASET   = 5'b01100,
      CL_ACLR   = 5'b01101,
      CL_CSET   = 5'b01110,
      CL_CCLR   = 5'b01111,
      CL_GSET   = 5'b10000,
      CL_GCLR   = 5'b10001,
      CL_VCLR   = 5'b10010
   } op_class_type;
endpackage

// ****************************************************************
// opcode and operand decode
// ****************************************************************
module bit_op_decode (
   input  wire logic [7:0]                  opcode_i,
   input  wire logic [7:0]                  byte1_i,
   input  wire logic [7:0]                  byte2_i,
   input  wire logic                        page_i,
   output bit_manip_pkg::op_class_type      cls_o,
   output logic      [2:0]                  cyc_o,
   output logic      [15:0]                 addr_o,
   output logic      [2:0]                  bitn_o,
   output logic                             inv_o,
   output logic                             rd_o,
   output logic                             wr_o
);
   import bit_manip_pkg::*;

   logic [15:0] word;
   logic [15:0] mb_addr;
   logic [15:0] dp_addr;
   logic [15:0] ab_addr;

   // operand forms: memory-bit word, direct page (G picks page), absolute
   assign word    = {byte2_i, byte1_i};
   assign mb_addr = {MB_ADDR_PAD, word[MB_ADDR_MSB:0]};
   assign dp_addr = {DP_PAGE_PAD, page_i, byte1_i};
   assign ab_addr = word;

   // class, length and operand per opcode
   always_comb begin
      cls_o  = CL_NONE;
      cyc_o  = CYC_SHORT;
      addr_o = mb_addr;
      bitn_o = word[MB_BIT_MSB:MB_BIT_LSB];
      inv_o  = word[MB_INV_POS];
      rd_o   = 1'b1;
      wr_o   = 1'b0;
      unique case (opcode_i)
         OP_CAND:   begin cls_o = CL_CAND;   cyc_o = CYC_CAND;   end
         OP_CXOR:   begin cls_o = CL_CXOR;   cyc_o = CYC_CXOR;   end
         OP_CLOAD:  begin cls_o = CL_CLOAD;  cyc_o = CYC_CLOAD;  end
         OP_COR:    begin cls_o = CL_COR;    cyc_o = CYC_COR;    end
         OP_MINV:   begin
            cls_o = CL_MINV;
            cyc_o = CYC_MINV;
            wr_o  = 1'b1;
         end
         OP_CSTORE: begin
            cls_o = CL_CSTORE;
            cyc_o = CYC_CSTORE;
            wr_o  = 1'b1;
         end
         OP_TST_DP: begin
            cls_o  = CL_TEST;
            cyc_o  = CYC_TST_DP;
            addr_o = dp_addr;
         end
         OP_TST_AB: begin
            cls_o  = CL_TEST;
            cyc_o  = CYC_TST_AB;
            addr_o = ab_addr;
         end
         OP_TCLR, OP_TSET: begin
            cls_o  = (opcode_i == OP_TCLR) ? CL_TCLR : CL_TSET;
            cyc_o  = CYC_TSTMOD;
            addr_o = ab_addr;
            wr_o   = 1'b1;
         end
         OP_ACLR, OP_ASET: begin
            cls_o  = (opcode_i == OP_ACLR) ? CL_ACLR : CL_ASET;
            bitn_o = byte1_i[ACC_BIT_MSB:0];
            rd_o   = 1'b0;
         end
         OP_CCLR:   begin cls_o = CL_CCLR; rd_o = 1'b0; end
         OP_CSET:   begin cls_o = CL_CSET; rd_o = 1'b0; end
         OP_GCLR:   begin cls_o = CL_GCLR; rd_o = 1'b0; end
         OP_GSET:   begin cls_o = CL_GSET; rd_o = 1'b0; end
         OP_VCLR:   begin cls_o = CL_VCLR; rd_o = 1'b0; end
         default: begin
            // direct-page set / clear families, bit number in the top field
            if (opcode_i[$bits(OP_DPBIT_LO)-1:0] == OP_DPBIT_LO) begin
               cls_o  = opcode_i[DP_CLR_POS] ? CL_MCLR : CL_MSET;
               cyc_o  = CYC_DPBIT;
               addr_o = dp_addr;
               bitn_o = opcode_i[DP_BIT_MSB:DP_BIT_LSB];
               wr_o   = 1'b1;
            end else begin
               rd_o = 1'b0;
            end
         end
      endcase
   end
endmodule // bit_op_decode

/* dv/bit_mem_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// data memory behind the execution unit
// ****************************************************************
module bit_mem_model (
   input  wire logic        clk_sys_i,
   input  wire logic        mem_rd_i,
   input  wire logic        mem_wr_i,
   input  wire logic [15:0] mem_addr_i,
   input  wire logic [7:0]  mem_wdata_i,
   output logic      [7:0]  mem_rdata_o
);
   logic [7:0] mem [0:4095];   // preset by the bench, so plain always below
   initial mem_rdata_o = 8'h00;
   // one cycle read latency; bus shows inverted junk when not answering
   always @(posedge clk_sys_i) begin
      if (mem_wr_i) begin
         mem[mem_addr_i[11:0]] <= mem_wdata_i;
      end
      mem_rdata_o <= mem_rd_i ? mem[mem_addr_i[11:0]] : ~mem_rdata_o;
   end
endmodule // bit_mem_model

/* dv/bit_manipulation_exec_unit_asserts.sv */
`timescale 1ns/1ps
// ****************************************************************
// port checker
// ****************************************************************
module bit_manipulation_exec_unit_asserts (
   input wire logic       clk_sys_i,
   input wire logic       nrst_i,
   input wire logic       start_i,
   input wire logic [7:0] opcode_i,
   input wire logic [7:0] byte1_i,
   input wire logic [7:0] acc_i,
   input wire logic [7:0] psw_i,
   input wire logic       busy_o,
   input wire logic       done_o,
   input wire logic [7:0] acc_o,
   input wire logic [7:0] psw_o,
   input wire logic       mem_rd_o,
   input wire logic       mem_wr_o
);
   import bit_manip_pkg::*;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   // an accepted request of one opcode
   sequence take(logic [7:0] op);
      start_i && !busy_o && opcode_i == op;
   endsequence
   sequence short_end;
      done_o && busy_o ##1 !busy_o;
   endsequence
   carry_clear_a: assert property (take(OP_CCLR) |=> psw_o == ($past(psw_i) & 8'hFE)
      ##0 short_end) else $error("carry clear wrong");
   carry_set_a: assert property (take(OP_CSET) |=> psw_o == ($past(psw_i) | 8'h01)
      ##0 short_end) else $error("carry set wrong");
   page_clear_a: assert property (take(OP_GCLR) |=> psw_o == ($past(psw_i) & 8'hDF)
      ##0 short_end) else $error("page clear wrong");
   page_set_a: assert property (take(OP_GSET) |=> psw_o == ($past(psw_i) | 8'h20)
      ##0 short_end) else $error("page set wrong");
   ovf_clear_a: assert property (take(OP_VCLR) |=> psw_o == ($past(psw_i) & 8'hBF)
      ##0 short_end) else $error("overflow clear wrong");
   acc_set_a: assert property (take(OP_ASET) |=> done_o && psw_o == $past(psw_i) &&
      acc_o == ($past(acc_i) | (8'h01 << $past(byte1_i[2:0])))) else $error("acc set wrong");
   acc_clear_a: assert property (take(OP_ACLR) |=> done_o && psw_o == $past(psw_i) &&
      acc_o == ($past(acc_i) & ~(8'h01 << $past(byte1_i[2:0])))) else $error("acc clear wrong");
   cand_time_a: assert property (take(OP_CAND) |=> (busy_o && !done_o)[*2]
      ##1 (busy_o && done_o) ##1 !busy_o) else $error("and length wrong");
   cstore_time_a: assert property (take(OP_CSTORE) |=> mem_rd_o ##4
      (mem_wr_o && done_o) ##1 !busy_o) else $error("store length wrong");
   dp_bit_a: assert property (start_i && !busy_o && opcode_i[3:0] == OP_DPBIT_LO
      |=> mem_rd_o ##2 (mem_wr_o && done_o && psw_o == $past(psw_i, 3)))
      else $error("page bit op wrong");
   test_time_a: assert property (take(OP_TST_AB) |=> mem_rd_o ##3 (done_o && !mem_wr_o))
      else $error("test length wrong");
   tset_time_a: assert property (take(OP_TSET) |=> mem_rd_o ##4 (mem_wr_o && done_o))
      else $error("test and set length wrong");
endmodule // bit_manipulation_exec_unit_asserts

bind bit_manipulation_exec_unit bit_manipulation_exec_unit_asserts u_chk (
   .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .start_i(start_i), .opcode_i(opcode_i),
   .byte1_i(byte1_i), .acc_i(acc_i), .psw_i(psw_i), .busy_o(busy_o), .done_o(done_o),
   .acc_o(acc_o), .psw_o(psw_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o));

/* dv/bit_manipulation_exec_unit_tb.sv */
`timescale 1ns/1ps
// ****************************************************************
// bench for the bit manipulation unit
// ****************************************************************
module bit_manipulation_exec_unit_tb;
   import bit_manip_pkg::*;
   logic        clk_sys_i, nrst_i, start_i, busy_o, done_o, illegal_o, mem_rd_o, mem_wr_o;
   logic [7:0]  opcode_i, byte1_i, byte2_i, acc_i, psw_i, mem_rdata_i;
   logic [7:0]  acc_o, psw_o, mem_wdata_o, hold_op;
   logic [15:0] mem_addr_o;
   int          miscompares, total_checks;

   bit_manipulation_exec_unit u_bit_manipulation_exec_unit (.clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i), .start_i(start_i), .opcode_i(opcode_i), .byte1_i(byte1_i),
      .byte2_i(byte2_i), .acc_i(acc_i), .psw_i(psw_i), .mem_rdata_i(mem_rdata_i),
      .busy_o(busy_o), .done_o(done_o), .illegal_o(illegal_o), .acc_o(acc_o),
      .psw_o(psw_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o),
      .mem_wdata_o(mem_wdata_o));
   bit_mem_model u_bit_mem_model (.clk_sys_i(clk_sys_i), .mem_rd_i(mem_rd_o),
      .mem_wr_i(mem_wr_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
      .mem_rdata_o(mem_rdata_i));

   initial begin
      clk_sys_i = 1'b0;
      forever #20 clk_sys_i = ~clk_sys_i;
   end

   task automatic print_verdict();
      if (miscompares == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", nm, exp, got);
         miscompares++;
      end
   endtask

   // one instruction, checked for length, results and memory byte afterwards
   task automatic exec(input logic [7:0] op, b1, b2, a, p, input int n,
                       input logic [7:0] ea, ep, input logic [11:0] ma, input logic [7:0] em);
      int c;
      @(posedge clk_sys_i);
      #1;
      start_i = 1'b1;
      opcode_i = op;
      byte1_i = b1;
      byte2_i = b2;
      acc_i = a;
      psw_i = p;
      @(posedge clk_sys_i);
      #1;
      start_i = (hold_op != 8'h00);   // a second request while busy must be dropped
      opcode_i = (hold_op != 8'h00) ? hold_op : op;
      hold_op = 8'h00;
      c = 2;
      while (done_o !== 1'b1 && c < 9) begin
         @(posedge clk_sys_i);
         #1;
         start_i = 1'b0;
         c++;
      end
      chk("cycles", n, c);
      chk("acc", ea, acc_o);
      chk("psw", ep, psw_o);
      @(posedge clk_sys_i);
      #1;
      chk("busy", 16'h0000, busy_o);
      chk("mem", em, u_bit_mem_model.mem[ma]);
   endtask

   initial begin
      #80000;
      miscompares++;
      print_verdict();
   end

   initial begin
      miscompares = 0;
      total_checks = 0;
      nrst_i = 1'b0;
      start_i = 1'b0;
      hold_op = 8'h00;
      {opcode_i, byte1_i, byte2_i, acc_i, psw_i} = '0;
      u_bit_mem_model.mem[12'h034] = 8'hA5;
      u_bit_mem_model.mem[12'h134] = 8'hC0;
      u_bit_mem_model.mem[12'h200] = 8'h0F;
      u_bit_mem_model.mem[12'h201] = 8'h10;
      u_bit_mem_model.mem[12'h040] = 8'h00;
      u_bit_mem_model.mem[12'h141] = 8'hFF;
      repeat (2) @(posedge clk_sys_i);
      #1;
      nrst_i = 1'b1;
      repeat (3) @(posedge clk_sys_i);
      #1;
      // opcode outside the group is flagged and never starts
      start_i = 1'b1;
      opcode_i = 8'hFF;
      @(posedge clk_sys_i);
      #1;
      start_i = 1'b0;
      chk("illegal", 16'h0001, illegal_o);
      chk("busy", 16'h0000, busy_o);
      exec(8'h8B, 8'h34, 8'h20, 8'h00, 8'hC3, 4, 8'h00, 8'hC3, 12'h034, 8'hA5);
      exec(8'h8B, 8'h34, 8'hA0, 8'h00, 8'hC3, 4, 8'h00, 8'hC2, 12'h034, 8'hA5);
      exec(8'hAB, 8'h34, 8'h20, 8'h00, 8'h01, 5, 8'h00, 8'h00, 12'h034, 8'hA5);
      exec(8'hAB, 8'h34, 8'h90, 8'h00, 8'h00, 5, 8'h00, 8'h01, 12'h034, 8'hA5);
      exec(8'hCB, 8'h34, 8'h10, 8'h00, 8'hFF, 4, 8'h00, 8'hFE, 12'h034, 8'hA5);
      exec(8'hCB, 8'h34, 8'h90, 8'h00, 8'h00, 4, 8'h00, 8'h01, 12'h034, 8'hA5);
      exec(8'h6B, 8'h34, 8'h20, 8'h00, 8'h00, 5, 8'h00, 8'h01, 12'h034, 8'hA5);
      exec(8'h6B, 8'h34, 8'hA0, 8'h00, 8'h00, 5, 8'h00, 8'h00, 12'h034, 8'hA5);
      exec(8'h4B, 8'h34, 8'h00, 8'h00, 8'h5A, 5, 8'h00, 8'h5A, 12'h034, 8'hA4);
      hold_op = OP_CSET;
      exec(8'hEB, 8'h34, 8'h70, 8'h00, 8'h5A, 6, 8'h00, 8'h5A, 12'h034, 8'h24);
      exec(8'h0C, 8'h34, 8'h00, 8'h3F, 8'h20, 4, 8'h3F, 8'hE2, 12'h134, 8'hC0);
      exec(8'h1C, 8'h34, 8'h00, 8'h04, 8'hC2, 5, 8'h04, 8'h00, 12'h034, 8'h24);
      exec(8'h5C, 8'h00, 8'h02, 8'h0F, 8'h80, 6, 8'h0F, 8'h02, 12'h200, 8'h00);
      exec(8'h3C, 8'h01, 8'h02, 8'h01, 8'h02, 6, 8'h01, 8'h80, 12'h201, 8'h11);
      exec(8'hA1, 8'h40, 8'h00, 8'h00, 8'h1F, 4, 8'h00, 8'h1F, 12'h040, 8'h20);
      exec(8'hD1, 8'h41, 8'h00, 8'h00, 8'h20, 4, 8'h00, 8'h20, 12'h141, 8'hBF);
      exec(8'h2B, 8'h03, 8'h00, 8'hFF, 8'h81, 2, 8'hF7, 8'h81, 12'h034, 8'h24);
      exec(8'h0B, 8'h07, 8'h00, 8'h00, 8'h81, 2, 8'h80, 8'h81, 12'h034, 8'h24);
      exec(8'h20, 8'h00, 8'h00, 8'h00, 8'hFF, 2, 8'h00, 8'hFE, 12'h034, 8'h24);
      exec(8'hA0, 8'h00, 8'h00, 8'h00, 8'h00, 2, 8'h00, 8'h01, 12'h034, 8'h24);
      exec(8'h40, 8'h00, 8'h00, 8'h00, 8'hFF, 2, 8'h00, 8'hDF, 12'h034, 8'h24);
      exec(8'hC0, 8'h00, 8'h00, 8'h00, 8'h00, 2, 8'h00, 8'h20, 12'h034, 8'h24);
      exec(8'h80, 8'h00, 8'h00, 8'h00, 8'hFF, 2, 8'h00, 8'hBF, 12'h034, 8'h24);
      print_verdict();
   end
endmodule // bit_manipulation_exec_unit_tb
